/* File: tone_steer_pkg.sv */
// Purpose: Shared constants and types for the tone digit steering latch.
// Assumes: 40 MHz system clock; AXI4-Lite register access, 32-bit data.
// Notes: Times are kept in their own units; cycle counts derive from them.
package tone_steer_pkg;

   // System clock rate
   localparam real CLOCK_HZ = 40.0e6;

   // Detection and output timing, in their printed units
   localparam real PRESENCE_DETECT_TIME_MS = 5.0;
   localparam real ABSENCE_DETECT_TIME_MS = 0.5;
   localparam real STEER_TO_CODE_DELAY_US = 11.0;
   localparam real STEER_TO_FLAG_DELAY_US = 16.0;
   localparam real CODE_TO_FLAG_SETUP_US = 3.4;
   localparam real WAKE_TIME_MS = 30.0;

   // Least times round up, longest times round down
   localparam int PRESENCE_CYC =
      int'($ceil(PRESENCE_DETECT_TIME_MS * CLOCK_HZ / 1.0e3));
   localparam int ABSENCE_CYC =
      int'($ceil(ABSENCE_DETECT_TIME_MS * CLOCK_HZ / 1.0e3));
   localparam int CODE_DELAY_MAX_CYC =
      int'($floor(STEER_TO_CODE_DELAY_US * CLOCK_HZ / 1.0e6));
   localparam int FLAG_DELAY_MAX_CYC =
      int'($floor(STEER_TO_FLAG_DELAY_US * CLOCK_HZ / 1.0e6));
   localparam int SETUP_CYC =
      int'($ceil(CODE_TO_FLAG_SETUP_US * CLOCK_HZ / 1.0e6));
   localparam int WAKE_CYC = int'($ceil(WAKE_TIME_MS * CLOCK_HZ / 1.0e3));

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

   // Field positions
   localparam int CTRL_PDN_BIT = 0;
   localparam int ST_CODE_LSB = 0;
   localparam int ST_EARLY_BIT = 4;
   localparam int ST_DELAYED_BIT = 5;
   localparam int ST_STEER_BIT = 6;
   localparam int ST_AWAKE_BIT = 7;
   localparam int ST_OE_BIT = 8;
   localparam int IRQ_LATCH_BIT = 0;
   localparam int IRQ_END_BIT = 1;
   localparam int IRQ_EARLY_BIT = 2;

   // Reset values and bus answers
   localparam logic [3:0] CODE_RST = 4'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Counter widths
   localparam int CNT_W = 21;
   localparam int SET_W = 8;

   // Steering sequence
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LATCH = 2'b01,
      ST_SETUP = 2'b10,
      ST_VALID = 2'b11
   } steer_st_t;

   // Whole block state, registered as one word
   typedef struct packed {
      logic [1:0] steerSync;
      logic [1:0] oeSync;
      logic [1:0] pdnSync;
      logic steerPrev;
      logic awake;
      logic [CNT_W-1:0] wakeCnt;
      logic earlyFlag;
      logic [CNT_W-1:0] detCnt;
      logic [3:0] heldCode;
      steer_st_t st;
      logic [SET_W-1:0] setupCnt;
      logic [3:0] code;
      logic codeOeN;
      logic delayedSteer;
      logic guardOut;
      logic guardOeN;
      logic ctrlPdn;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic irq;
      logic awready;
      logic wready;
      logic haveAw;
      logic haveW;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_t;

endpackage

/* File: tone_digit_steering_latch.sv */
// Purpose: Digital back end of a dual-tone receiver: detection timing,
//    guard-time steering through an external RC, digit latch, bus slave.
// Assumes: Tone decisions arrive from the filter section on this clock;
//    steering, enable and power-down pins are asynchronous.
// Notes: Three-state pins are split into out and active-low enable.
//
// Function
// R01 - Short bursts leave digit code unchanged
// R02 - Valid duration tone is decoded and latched
// R03 - Code held until next valid tone
// R04 - Enable low puts code outputs high impedance
// R05 - Latching continues while outputs are disabled
// R06 - Short dropout does not end the tone
// R07 - Early flag marks valid tone pair
// R08 - Guard pin drives RC and senses steering
// R09 - Delayed steer follows guard present and absent
// R10 - Sixteen pairs shown as four-bit code
// R11 - Presence recognised 5 to 14 ms
// R12 - Absence recognised 0.5 to 8.5 ms
// R13 - Code updates within 11 us of steer
// R14 - Delayed steer rises within 16 us
// R15 - Code valid 3.4 us before delayed steer
// R16 - Early flag 30 ms after power-up
// R17 - System sets guard times via RC
// R18 - Steering sensed by threshold crossing
// R19 - All timing derived from one clock
`timescale 1ns/1ps
module tone_digit_steering_latch #(
   parameter int unsigned PRESENCE_CYC = tone_steer_pkg::PRESENCE_CYC,
   parameter int unsigned ABSENCE_CYC = tone_steer_pkg::ABSENCE_CYC,
   parameter int unsigned WAKE_CYC = tone_steer_pkg::WAKE_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   // Filter section decisions
   input wire logic toneValid,
   input wire logic [3:0] toneCode,
   // Pins
   input wire logic steerGuardIn,
   output logic steerGuardOut,
   output logic steerGuardOeN,
   input wire logic codeOutputEnable,
   input wire logic powerDownIn,
   output logic [3:0] digitCodeOut,
   output logic digitCodeOeN,
   output logic earlyToneFlag,
   output logic delayedSteerOut,
   output logic irq,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   // Current and next block state
   tone_steer_pkg::state_t s_q;
   tone_steer_pkg::state_t s_d;

   // Wake waits so the first early flag lands at the wake time
   localparam int unsigned WAKE_WAIT =
      (WAKE_CYC > PRESENCE_CYC) ? WAKE_CYC - PRESENCE_CYC : 1;
   localparam logic [tone_steer_pkg::CNT_W-1:0] WAKE_END =
      tone_steer_pkg::CNT_W'(WAKE_WAIT - 1);
   localparam logic [tone_steer_pkg::CNT_W-1:0] PRES_END =
      tone_steer_pkg::CNT_W'(PRESENCE_CYC - 1);
   localparam logic [tone_steer_pkg::CNT_W-1:0] ABS_END =
      tone_steer_pkg::CNT_W'(ABSENCE_CYC - 1);
   localparam logic [tone_steer_pkg::SET_W-1:0] SETUP_END =
      tone_steer_pkg::SET_W'(tone_steer_pkg::SETUP_CYC - 1);

   // Outputs come straight from state flops
   assign steerGuardOut = s_q.guardOut;
   assign steerGuardOeN = s_q.guardOeN;
   assign digitCodeOut = s_q.code;
   assign digitCodeOeN = s_q.codeOeN;
   assign earlyToneFlag = s_q.earlyFlag;
   assign delayedSteerOut = s_q.delayedSteer;
   assign irq = s_q.irq;
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bresp = s_q.bresp;
   assign bvalid = s_q.bvalid;
   assign arready = s_q.arready;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign rvalid = s_q.rvalid;

   // Next-state logic for the whole block
   always_comb begin
      logic pdn;
      logic steerNow;
      logic steerRise;
      logic steerFall;
      logic [2:0] irqSet;
      logic [2:0] irqClr;
      logic doWrite;
      logic [31:0] rd;
      logic [31:0] wmask;
      logic [31:0] wv;
      pdn = 1'b0;
      steerNow = 1'b0;
      steerRise = 1'b0;
      steerFall = 1'b0;
      irqSet = 3'h0;
      irqClr = 3'h0;
      doWrite = 1'b0;
      rd = 32'h0;
      wmask = 32'h0;
      wv = 32'h0;
      s_d = s_q;

      // Pins pass two flops; only the second stage is read below
      s_d.steerSync = {s_q.steerSync[0], steerGuardIn};
      s_d.oeSync = {s_q.oeSync[0], codeOutputEnable};
      s_d.pdnSync = {s_q.pdnSync[0], powerDownIn};
      pdn = s_q.pdnSync[1] | s_q.ctrlPdn;

      // R18 threshold crossing
      // Comparator sits outside; a crossing is a change of the sensed level
      steerNow = s_q.steerSync[1];
      s_d.steerPrev = steerNow;
      steerRise = steerNow & ~s_q.steerPrev;
      steerFall = ~steerNow & s_q.steerPrev;

      // Power-down and wake-up sequencing
      if (pdn) begin
         s_d.awake = 1'b0;
         s_d.wakeCnt = '0;
      end else if (!s_q.awake) begin
         // R16 wake delay
         if (s_q.wakeCnt == WAKE_END) begin
            s_d.awake = 1'b1;
         end else begin
            s_d.wakeCnt = s_q.wakeCnt + 1'b1;
         end
      end

      // Tone presence and absence detection on the one system clock
      // R19 single clock timing
      if (!s_q.awake) begin
         // Detector is asleep; the latched digit is kept
         s_d.earlyFlag = 1'b0;
         s_d.detCnt = '0;
      end else if (!s_q.earlyFlag) begin
         if (!toneValid) begin
            s_d.detCnt = '0;
         end else if (s_q.detCnt == PRES_END) begin
            // R11 presence time
            // R07 early flag set
            s_d.earlyFlag = 1'b1;
            s_d.heldCode = toneCode;
            s_d.detCnt = '0;
            irqSet[tone_steer_pkg::IRQ_EARLY_BIT] = 1'b1;
         end else begin
            s_d.detCnt = s_q.detCnt + 1'b1;
         end
      end else begin
         if (toneValid) begin
            s_d.detCnt = '0;
         end else if (s_q.detCnt == ABS_END) begin
            // R12 absence time
            s_d.earlyFlag = 1'b0;
            s_d.detCnt = '0;
         end else begin
            s_d.detCnt = s_q.detCnt + 1'b1;
         end
      end

      // R08 guard output drive
      // The RC integrates the early flag; pin released while asleep
      s_d.guardOut = s_d.earlyFlag;
      s_d.guardOeN = ~s_d.awake;

      // Steering sequence: latch, setup delay, then delayed steer
      unique case (s_q.st)
         tone_steer_pkg::ST_IDLE: begin
            // R01 no latch on burst
            // Bursts too short never lift the RC past threshold
            if (steerRise) begin
               s_d.st = tone_steer_pkg::ST_LATCH;
            end
         end
         tone_steer_pkg::ST_LATCH: begin
            // R02 decode and latch
            // R10 four-bit code
            // R13 code within limit
            // R05 latch while disabled
            s_d.code = s_q.heldCode;
            s_d.setupCnt = '0;
            irqSet[tone_steer_pkg::IRQ_LATCH_BIT] = 1'b1;
            s_d.st = tone_steer_pkg::ST_SETUP;
         end
         tone_steer_pkg::ST_SETUP: begin
            // R15 code before steer
            if (!steerNow) begin
               s_d.st = tone_steer_pkg::ST_IDLE;
            end else if (s_q.setupCnt == SETUP_END) begin
               // R14 steer within limit
               s_d.delayedSteer = 1'b1;
               s_d.st = tone_steer_pkg::ST_VALID;
            end else begin
               s_d.setupCnt = s_q.setupCnt + 1'b1;
            end
         end
         tone_steer_pkg::ST_VALID: begin
            // R09 release on absence
            // R06 dropout ignored
            // R03 code held
            // A dropout shorter than the RC decay never drops the steer
            if (steerFall) begin
               s_d.delayedSteer = 1'b0;
               s_d.st = tone_steer_pkg::ST_IDLE;
               irqSet[tone_steer_pkg::IRQ_END_BIT] = 1'b1;
            end
         end
      endcase

      // R04 high impedance
      s_d.codeOeN = ~s_q.oeSync[1];

      // Write address and data are taken in either order
      if (awvalid && s_q.awready) begin
         s_d.awready = 1'b0;
         s_d.haveAw = 1'b1;
         s_d.awAddr = awaddr;
      end else if (!s_q.haveAw && !s_q.bvalid) begin
         s_d.awready = 1'b1;
      end
      if (wvalid && s_q.wready) begin
         s_d.wready = 1'b0;
         s_d.haveW = 1'b1;
         s_d.wData = wdata;
         s_d.wStrb = wstrb;
      end else if (!s_q.haveW && !s_q.bvalid) begin
         s_d.wready = 1'b1;
      end

      // Both halves held: perform write and raise the response
      if (s_q.haveAw && s_q.haveW && !s_q.bvalid) begin
         doWrite = 1'b1;
         s_d.haveAw = 1'b0;
         s_d.haveW = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = tone_steer_pkg::RESP_OKAY;
         for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_q.wStrb[i]}};
         end
         wv = s_q.wData & wmask;
         unique case ({s_q.awAddr[7:2], 2'b00})
            tone_steer_pkg::CTRL_OFS: begin
               if (s_q.wStrb[0]) begin
                  s_d.ctrlPdn = wv[tone_steer_pkg::CTRL_PDN_BIT];
               end
            end
            tone_steer_pkg::STATUS_OFS: begin
               // Read-only; write ignored
            end
            tone_steer_pkg::IRQ_STAT_OFS: begin
               irqClr = wv[2:0];
            end
            tone_steer_pkg::IRQ_MASK_OFS: begin
               if (s_q.wStrb[0]) begin
                  s_d.irqMask = wv[2:0];
               end
            end
            default: begin
               s_d.bresp = tone_steer_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end

      // Read channel: one read at a time
      if (arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rresp = tone_steer_pkg::RESP_OKAY;
         unique case ({araddr[7:2], 2'b00})
            tone_steer_pkg::CTRL_OFS: begin
               rd[tone_steer_pkg::CTRL_PDN_BIT] = s_q.ctrlPdn;
            end
            tone_steer_pkg::STATUS_OFS: begin
               rd[tone_steer_pkg::ST_CODE_LSB +: 4] = s_q.code;
               rd[tone_steer_pkg::ST_EARLY_BIT] = s_q.earlyFlag;
               rd[tone_steer_pkg::ST_DELAYED_BIT] = s_q.delayedSteer;
               rd[tone_steer_pkg::ST_STEER_BIT] = steerNow;
               rd[tone_steer_pkg::ST_AWAKE_BIT] = s_q.awake;
               rd[tone_steer_pkg::ST_OE_BIT] = s_q.oeSync[1];
            end
            tone_steer_pkg::IRQ_STAT_OFS: begin
               rd[2:0] = s_q.irqStat;
            end
            tone_steer_pkg::IRQ_MASK_OFS: begin
               rd[2:0] = s_q.irqMask;
            end
            default: begin
               s_d.rresp = tone_steer_pkg::RESP_SLVERR;
            end
         endcase
         s_d.rdata = rd;
      end else if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
         s_d.arready = 1'b1;
      end else if (!s_q.rvalid) begin
         s_d.arready = 1'b1;
      end

      // Sticky events: a new event wins over a clear in the same cycle
      s_d.irqStat = (s_q.irqStat & ~irqClr) | irqSet;
      s_d.irq = |(s_d.irqStat & s_q.irqMask);
      if (!doWrite) begin
         s_d.irqStat = (s_q.irqStat & ~irqClr) | irqSet;
      end
   end

   // State register; reset loads constants only
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.st <= tone_steer_pkg::ST_IDLE;
         s_q.code <= tone_steer_pkg::CODE_RST;
         s_q.heldCode <= tone_steer_pkg::CODE_RST;
         s_q.codeOeN <= 1'b1;
         s_q.guardOeN <= 1'b1;
         s_q.irqMask <= tone_steer_pkg::IRQ_MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

/* File: tone_steer_monitor.sv */
// Purpose: Port timing checks for the steering latch.
// Assumes: One clock; nrst asynchronous, active low.
// Notes: Bounds leave room for the two-flop pin synchronisers.
`timescale 1ns/1ps
module tone_steer_monitor #(
   parameter int unsigned PRESENCE_CYC = 20,
   parameter int unsigned ABSENCE_CYC = 8,
   parameter int unsigned WAKE_CYC = 40
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic toneValid,
   input wire logic steerGuardIn,
   input wire logic steerGuardOut,
   input wire logic codeOutputEnable,
   input wire logic [3:0] digitCodeOut,
   input wire logic digitCodeOeN,
   input wire logic earlyToneFlag,
   input wire logic delayedSteerOut,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready
);
   // Run lengths of tone, silence, steering; age since reset
   int hiCnt, loCnt, stCnt, upCnt;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hiCnt <= 0;
         loCnt <= 0;
         stCnt <= 0;
         upCnt <= 0;
      end else begin
         hiCnt <= toneValid ? hiCnt + 1 : 0;
         loCnt <= toneValid ? 0 : loCnt + 1;
         stCnt <= steerGuardIn ? stCnt + 1 : 0;
         // Saturates so the lag check waits out the synchronisers
         upCnt <= (upCnt < 7) ? upCnt + 1 : upCnt;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_early_rise: assert property ($rose(earlyToneFlag) |->
      hiCnt + 2 >= PRESENCE_CYC) else $error("early flag rose too soon");
   a_early_fall: assert property ($fell(earlyToneFlag) |->
      loCnt + 2 >= ABSENCE_CYC) else $error("early flag fell too soon");
   a_guard_mirror: assert property (steerGuardOut == earlyToneFlag)
      else $error("guard drive differs from early flag");
   a_code_enable: assert property (upCnt >= 4 |->
      digitCodeOeN == !$past(codeOutputEnable, 3))
      else $error("code enable lag wrong");
   a_code_cause: assert property ($changed(digitCodeOut) |->
      $past(steerGuardIn, 2) && !delayedSteerOut)
      else $error("code changed without steering");
   a_setup_delay: assert property ($rose(delayedSteerOut) |->
      stCnt >= tone_steer_pkg::SETUP_CYC &&
      stCnt <= tone_steer_pkg::FLAG_DELAY_MAX_CYC)
      else $error("delayed steer out of window");
   a_steer_drop: assert property ($fell(steerGuardIn) |->
      ##[0:5] !delayedSteerOut) else $error("delayed steer stuck high");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_read_hold: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata)) else $error("read data dropped");
   c_latch: cover property ($rose(delayedSteerOut));
   c_hiz_update: cover property (digitCodeOeN && $changed(digitCodeOut));
   c_tone_end: cover property (delayedSteerOut && $fell(toneValid));
endmodule
bind tone_digit_steering_latch tone_steer_monitor #(
   .PRESENCE_CYC(PRESENCE_CYC), .ABSENCE_CYC(ABSENCE_CYC),
   .WAKE_CYC(WAKE_CYC)) mon (.clock, .nrst, .toneValid, .steerGuardIn,
   .steerGuardOut, .codeOutputEnable, .digitCodeOut, .digitCodeOeN,
   .earlyToneFlag, .delayedSteerOut, .arvalid, .arready, .rdata,
   .rvalid, .rready);

/* File: tone_host_model.sv */
// Purpose: Guard RC network plus the host that reads the digit code.
// Assumes: RC charge and discharge are linear in clock cycles.
// Notes: Undriven code pins show the inverse of the last driven code.
`timescale 1ns/1ps
module tone_host_model #(
   parameter int GUARD = 24
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic guardOut,
   input wire logic guardOeN,
   input wire logic delayedSteer,
   input wire logic [3:0] codeOut,
   input wire logic codeOeN,
   output logic steerIn,
   output logic [3:0] codeWire,
   output logic [3:0] codeSeen
);
   int charge; // RC level, in cycles of drive
   logic [3:0] lastDriven;
   logic dsPrev;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         charge <= 0;
         steerIn <= 1'b0;
      end else begin
         // A released guard pin discharges like a low drive
         if (!guardOeN && guardOut && charge < GUARD) begin
            charge <= charge + 1;
         end else if (!(!guardOeN && guardOut) && charge > 0) begin
            charge <= charge - 1;
         end
         // Hysteresis: full charge sets, full discharge clears
         if (charge == GUARD) begin
            steerIn <= 1'b1;
         end else if (charge == 0) begin
            steerIn <= 1'b0;
         end
      end
   end
   assign codeWire = codeOeN ? ~lastDriven : codeOut;
   // Host samples the code on the delayed steer rising edge
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lastDriven <= 4'h0;
         dsPrev <= 1'b0;
         codeSeen <= 4'h0;
      end else begin
         // Only a driven bus updates what the pins remember
         if (!codeOeN) begin
            lastDriven <= codeOut;
         end
         dsPrev <= delayedSteer;
         if (delayedSteer && !dsPrev) begin
            codeSeen <= codeWire;
         end
      end
   end
endmodule

/* File: tone_digit_steering_latch_test.sv */
// Purpose: Self-checking bench for the steering latch and its bus.
// Assumes: Short detection counts; host model closes the guard loop.
// Notes: Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module tone_digit_steering_latch_test;
   localparam int unsigned PRES = 20;
   localparam int unsigned ABS = 8;
   localparam int unsigned WAKE = 40;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic toneValid = 1'b1;
   logic [3:0] toneCode = 4'h0;
   logic codeOutputEnable = 1'b1;
   logic powerDownIn = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic steerGuardIn, steerGuardOut, steerGuardOeN, digitCodeOeN;
   logic earlyToneFlag, delayedSteerOut, irq, awready, wready, bvalid;
   logic arready, rvalid;
   logic [3:0] digitCodeOut, codeWire, codeSeen;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int mismatches = 0;
   int n_compared = 0;
   always #12.5 clock = ~clock;
   tone_digit_steering_latch #(.PRESENCE_CYC(PRES), .ABSENCE_CYC(ABS),
      .WAKE_CYC(WAKE)) dut (.clock, .nrst, .toneValid, .toneCode,
      .steerGuardIn, .steerGuardOut, .steerGuardOeN, .codeOutputEnable,
      .powerDownIn, .digitCodeOut, .digitCodeOeN, .earlyToneFlag,
      .delayedSteerOut, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready);
   tone_host_model host (.clock, .nrst, .guardOut(steerGuardOut),
      .guardOeN(steerGuardOeN), .delayedSteer(delayedSteerOut),
      .codeOut(digitCodeOut), .codeOeN(digitCodeOeN),
      .steerIn(steerGuardIn), .codeWire, .codeSeen);
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task test_done;
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded wait for the delayed steer level
   task automatic wait_ds(input logic lvl);
      int n;
      n = 0;
      while (delayedSteerOut !== lvl && n < 600) begin
         @(posedge clock);
         n++;
      end
      chk(delayedSteerOut, lvl);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
         output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 50);
      r = bresp;
      bready <= 1'b0;
      chk(n < 50, 1'b1);
      @(posedge clock);
   endtask
   // Ready for the answer only after the address is taken
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
         output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         else if (!arvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready) && n < 50);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(n < 50, 1'b1);
   endtask
   // One full valid tone; host sees the code only while enabled
   task automatic digit(input logic [3:0] d);
      toneCode <= d;
      toneValid <= 1'b1;
      wait_ds(1'b1);
      chk(digitCodeOut, d);
      @(posedge clock);
      chk(codeSeen === d, codeOutputEnable);
      toneValid <= 1'b0;
      wait_ds(1'b0);
      chk(digitCodeOut, d);
   endtask
   task automatic t_wake;
      int n;
      n = 0;
      powerDownIn <= 1'b0;
      while (earlyToneFlag !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk(n >= WAKE && n <= WAKE + 6, 1'b1);
      digit(4'h0);
   endtask
   task automatic t_short;
      toneCode <= 4'h5;
      toneValid <= 1'b1;
      repeat (PRES - 4) @(posedge clock);
      chk(earlyToneFlag, 1'b0);
      repeat (10) @(posedge clock);
      chk(earlyToneFlag, 1'b1);
      toneValid <= 1'b0;
      repeat (40) @(posedge clock);
      chk(digitCodeOut, 4'hf);
      chk(delayedSteerOut, 1'b0);
   endtask
   task automatic t_dropout;
      toneCode <= 4'h6;
      toneValid <= 1'b1;
      wait_ds(1'b1);
      toneValid <= 1'b0;
      repeat (ABS - 3) @(posedge clock);
      toneValid <= 1'b1;
      repeat (4) @(posedge clock);
      chk(earlyToneFlag, 1'b1);
      chk(delayedSteerOut, 1'b1);
      chk(digitCodeOut, 4'h6);
      toneValid <= 1'b0;
      wait_ds(1'b0);
   endtask
   task automatic t_hiz;
      codeOutputEnable <= 1'b0;
      repeat (4) @(posedge clock);
      chk(digitCodeOeN, 1'b1);
      digit(4'h3);
      codeOutputEnable <= 1'b1;
      repeat (4) @(posedge clock);
      chk(digitCodeOeN, 1'b0);
      chk(codeWire, 4'h3);
   endtask
   // Status read, unmapped access, interrupt mask and clear
   task automatic t_bus;
      logic [31:0] v;
      logic [1:0] r;
      axi_rd(tone_steer_pkg::STATUS_OFS, v, r);
      chk(r, tone_steer_pkg::RESP_OKAY);
      chk(v[8:0], 9'h183);
      axi_rd(8'h10, v, r);
      chk(r, tone_steer_pkg::RESP_SLVERR);
      chk(v, 32'h0);
      axi_wr(8'h10, 32'h1, r);
      chk(r, tone_steer_pkg::RESP_SLVERR);
      chk(irq, 1'b0);
      axi_wr(tone_steer_pkg::IRQ_MASK_OFS, 32'h1, r);
      chk(r, tone_steer_pkg::RESP_OKAY);
      repeat (3) @(posedge clock);
      chk(irq, 1'b1);
      axi_wr(tone_steer_pkg::IRQ_STAT_OFS, 32'h7, r);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      digit(4'ha);
      chk(irq, 1'b1);
      // Early rise, latch and steer end each leave a sticky bit
      axi_rd(tone_steer_pkg::IRQ_STAT_OFS, v, r);
      chk(v, 32'h7);
      // Software power-down releases the guard pin and sleeps
      axi_wr(tone_steer_pkg::CTRL_OFS, 32'h1, r);
      repeat (4) @(posedge clock);
      chk(steerGuardOeN, 1'b1);
      axi_rd(tone_steer_pkg::STATUS_OFS, v, r);
      chk(v[tone_steer_pkg::ST_AWAKE_BIT], 1'b0);
      axi_wr(tone_steer_pkg::CTRL_OFS, 32'h0, r);
      repeat (WAKE) @(posedge clock);
      axi_rd(tone_steer_pkg::STATUS_OFS, v, r);
      chk(v[tone_steer_pkg::ST_AWAKE_BIT], 1'b1);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      chk({digitCodeOeN, steerGuardOeN, digitCodeOut}, 6'h30);
      nrst <= 1'b1;
      t_wake();
      for (int i = 1; i < 16; i++) begin
         digit(i[3:0]);
      end
      t_short();
      t_dropout();
      t_hiz();
      t_bus();
      test_done();
   end
   // Hang guard, well past the expected run length
   initial begin
      repeat (30000) @(posedge clock);
      mismatches++;
      test_done();
   end
endmodule
